// ==== rtl/hpt_pkg.sv ====
// Purpose: shared constants for the host to pci i/o and configuration translator
// Assumes: 34-bit host address, 32-bit apb register bus
// Notes: pci command codes follow the published pci bus encoding
package hpt_pkg;
    localparam int HOST_AW = 34;
    localparam int APB_AW = 12;
    // host address decode
    localparam logic [1:0] QUAD_IO = 2'h1;
    localparam logic [3:0] WIN_IACK_CODE = 4'hB;
    localparam logic [2:0] WIN_IO_CODE = 3'h6;
    localparam logic [2:0] WIN_CFG_CODE = 3'h7;
    // pci bus commands
    localparam logic [3:0] CMD_IACK = 4'h0;
    localparam logic [3:0] CMD_SPECIAL = 4'h1;
    localparam logic [3:0] CMD_IO_RD = 4'h2;
    localparam logic [3:0] CMD_IO_WR = 4'h3;
    localparam logic [3:0] CMD_CFG_RD = 4'hA;
    localparam logic [3:0] CMD_CFG_WR = 4'hB;
    // configuration target bus select
    localparam logic [1:0] BUS_PRIMARY = 2'h0;
    localparam logic [1:0] BUS_SECONDARY = 2'h1;
    // highest primary device that owns an idsel line
    localparam logic [4:0] IDSEL_MAX_DEV = 5'h14;
    localparam int IDSEL_W = 21;
    // fixed-zero extension value
    localparam logic [7:0] FIXED_EXT_VAL = 8'h00;
    // register offsets (byte addresses)
    localparam logic [APB_AW-1:0] REG_FIXED_EXT = 12'h000;
    localparam logic [APB_AW-1:0] REG_PROG_EXT = 12'h004;
    localparam logic [APB_AW-1:0] REG_STATUS = 12'h008;
    // reset values
    localparam logic [31:0] PROG_EXT_RST = 32'h0000_0000;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    // status field positions
    localparam int ST_CMD_LSB = 16;
    localparam int ST_ILLEGAL_BIT = 20;
    localparam int ST_MISS_BIT = 21;
    // decoded host windows
    typedef enum logic [1:0] {
        HPT_WIN_NONE,
        HPT_WIN_IACK,
        HPT_WIN_IO,
        HPT_WIN_CFG
    } hpt_win_e;
endpackage : hpt_pkg

// ==== rtl/hpt_lane_decode.sv ====
// Purpose: size and lane decode into active-low byte enables and ad<2:0>
// Assumes: address bits 7:3 of a sparse-space host access
// Notes: purely combinational
`timescale 1ns/1ps
module hpt_lane_decode
    import hpt_pkg::*;
(
    input wire logic [7:3] addr_i,
    output logic [3:0] be_n_o,
    output logic [2:0] ad_low_o,
    output logic legal_o
);
    logic [1:0] lane;
    logic [1:0] size;

    assign lane = addr_i[6:5];
    assign size = addr_i[4:3];

    always_comb
    begin
        be_n_o = 4'hF;
        ad_low_o = {addr_i[7], lane};
        legal_o = 1'b1;
        case (size)
            2'h0:
            begin
                be_n_o = ~(4'h1 << lane);
            end
            2'h1:
            begin
                if (lane != 2'h3)
                begin
                    be_n_o = ~(4'h3 << lane);
                end
                else
                begin
                    legal_o = 1'b0;
                end
            end
            2'h2:
            begin
                if (lane[1] == 1'b0)
                begin
                    be_n_o = ~(4'h7 << lane);
                end
                else
                begin
                    legal_o = 1'b0;
                end
            end
            default:
            begin
                if (lane == 2'h0)
                begin
                    be_n_o = 4'h0;
                end
                else if (lane == 2'h3)
                begin
                    be_n_o = 4'h0;
                    ad_low_o = 3'h0;
                end
                else
                begin
                    legal_o = 1'b0;
                end
            end
        endcase
    end
endmodule : hpt_lane_decode

// ==== rtl/hpt_bridge.sv ====
// Purpose: translate host accesses in the iack, sparse i/o and config windows to pci
// Assumes: one host request per cycle at most, same clock; apb slave with zero wait
// Notes: one registered cycle from host request to pci address phase
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module hpt_bridge
    import hpt_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // host side
    input wire logic host_req_i,
    input wire logic host_write_i,
    input wire logic [hpt_pkg::HOST_AW-1:0] host_address_i,
    // pci address phase
    output logic pci_req_o,
    output logic [3:0] pci_cmd_o,
    output logic [31:0] pci_ad_o,
    output logic [3:0] pci_cbe_n_o,
    output logic pci_illegal_o,
    output logic host_miss_o,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [hpt_pkg::APB_AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);
    import hpt_pkg::*;

    hpt_win_e win;
    logic [3:0] lane_be_n;
    logic [2:0] lane_ad;
    logic lane_legal;
    logic [7:0] ext_hi;
    logic [IDSEL_W-1:0] idsel;
    logic [4:0] dev;
    logic req_q, req_d;
    logic [3:0] cmd_q, cmd_d;
    logic [31:0] ad_q, ad_d;
    logic [3:0] be_n_q, be_n_d;
    logic illegal_q, illegal_d;
    logic miss_q, miss_d;
    logic [31:0] prog_ext_q, prog_ext_d;
    logic [15:0] count_q, count_d;
    logic [3:0] last_cmd_q, last_cmd_d;
    logic last_illegal_q, last_illegal_d;
    logic last_miss_q, last_miss_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic apb_setup;
    logic apb_write;

    hpt_lane_decode u_lane
    (
        .addr_i(host_address_i[7:3]),
        .be_n_o(lane_be_n),
        .ad_low_o(lane_ad),
        .legal_o(lane_legal)
    );

    always_comb
    begin
        win = HPT_WIN_NONE;
        if (host_address_i[33:32] == QUAD_IO)
        begin
            if (host_address_i[31:28] == WIN_IACK_CODE)
            begin
                win = HPT_WIN_IACK;
            end
            else if (host_address_i[31:29] == WIN_IO_CODE)
            begin
                win = HPT_WIN_IO;
            end
            else if (host_address_i[31:29] == WIN_CFG_CODE)
            begin
                win = HPT_WIN_CFG;
            end
        end
    end

    assign ext_hi = (host_address_i[28:23] == 6'h00) ? FIXED_EXT_VAL : prog_ext_q[31:24];

    assign dev = host_address_i[20:16];
    assign idsel = (dev <= IDSEL_MAX_DEV) ? IDSEL_W'(21'h000001 << dev) : '0;

    // address phase translation
    always_comb
    begin
        req_d = 1'b0;
        cmd_d = cmd_q;
        ad_d = ad_q;
        be_n_d = be_n_q;
        illegal_d = 1'b0;
        miss_d = 1'b0;
        if (host_req_i)
        begin
            case (win)
                HPT_WIN_IACK:
                begin
                    req_d = 1'b1;
                    ad_d = 32'h0000_0000;
                    if (host_write_i)
                    begin
                        cmd_d = CMD_SPECIAL;
                        be_n_d = 4'h0;
                    end
                    else
                    begin
                        cmd_d = CMD_IACK;
                        be_n_d = lane_be_n;
                        illegal_d = ~lane_legal;
                    end
                end
                HPT_WIN_IO:
                begin
                    req_d = 1'b1;
                    cmd_d = host_write_i ? CMD_IO_WR : CMD_IO_RD;
                    ad_d = {ext_hi, host_address_i[28:8], lane_ad};
                    be_n_d = lane_be_n;
                    illegal_d = ~lane_legal;
                end
                HPT_WIN_CFG:
                begin
                    req_d = 1'b1;
                    cmd_d = host_write_i ? CMD_CFG_WR : CMD_CFG_RD;
                    be_n_d = lane_be_n;
                    illegal_d = ~lane_legal;
                    if (prog_ext_q[1:0] == BUS_PRIMARY)
                    begin
                        ad_d = {idsel, host_address_i[15:13], host_address_i[12:7],
                            prog_ext_q[1:0]};
                    end
                    else
                    begin
                        ad_d = {8'h00, host_address_i[28:21], host_address_i[20:16],
                            host_address_i[15:13], host_address_i[12:7], prog_ext_q[1:0]};
                    end
                end
                default:
                begin
                    miss_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            req_q <= 1'b0;
            cmd_q <= CMD_IACK;
            ad_q <= 32'h0000_0000;
            be_n_q <= 4'hF;
            illegal_q <= 1'b0;
            miss_q <= 1'b0;
        end
        else
        begin
            req_q <= req_d;
            cmd_q <= cmd_d;
            ad_q <= ad_d;
            be_n_q <= be_n_d;
            illegal_q <= illegal_d;
            miss_q <= miss_d;
        end
    end

    assign pci_req_o = req_q;
    assign pci_cmd_o = cmd_q;
    assign pci_ad_o = ad_q;
    assign pci_cbe_n_o = be_n_q;
    assign pci_illegal_o = illegal_q;
    assign host_miss_o = miss_q;

    // apb register file
    assign apb_setup = psel_i & ~penable_i;
    assign apb_write = psel_i & penable_i & pready_q & pwrite_i;

    always_comb
    begin
        prog_ext_d = prog_ext_q;
        count_d = count_q;
        last_cmd_d = last_cmd_q;
        last_illegal_d = last_illegal_q;
        last_miss_d = last_miss_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        if (apb_write && paddr_i == REG_PROG_EXT)
        begin
            prog_ext_d = pwdata_i;
        end
        if (req_q)
        begin
            count_d = count_q + 16'h0001;
            last_cmd_d = cmd_q;
            last_illegal_d = illegal_q;
        end
        if (req_q || miss_q)
        begin
            last_miss_d = miss_q;
        end
        if (apb_setup)
        begin
            pready_d = 1'b1;
            case (paddr_i)
                REG_FIXED_EXT:
                begin
                    prdata_d = {24'h000000, FIXED_EXT_VAL};
                end
                REG_PROG_EXT:
                begin
                    prdata_d = prog_ext_q;
                end
                REG_STATUS:
                begin
                    prdata_d = 32'h0000_0000;
                    prdata_d[15:0] = count_q;
                    prdata_d[ST_CMD_LSB +: 4] = last_cmd_q;
                    prdata_d[ST_ILLEGAL_BIT] = last_illegal_q;
                    prdata_d[ST_MISS_BIT] = last_miss_q;
                end
                default:
                begin
                    prdata_d = 32'h0000_0000;
                    pslverr_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            prog_ext_q <= PROG_EXT_RST;
            count_q <= COUNT_RST;
            last_cmd_q <= CMD_IACK;
            last_illegal_q <= 1'b0;
            last_miss_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            prog_ext_q <= prog_ext_d;
            count_q <= count_d;
            last_cmd_q <= last_cmd_d;
            last_illegal_q <= last_illegal_d;
            last_miss_q <= last_miss_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;

    // checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    AST_MISS_NO_CYCLE: assert property (
        host_req_i && win == HPT_WIN_NONE |=> !pci_req_o && host_miss_o)
        else $error("access outside windows produced a pci cycle");
    AST_IACK_READ: assert property (
        host_req_i && win == HPT_WIN_IACK && !host_write_i
        |=> pci_req_o && pci_cmd_o == CMD_IACK && pci_cbe_n_o == $past(lane_be_n))
        else $error("iack read did not give interrupt acknowledge");
    AST_SPECIAL_WRITE: assert property (
        host_req_i && win == HPT_WIN_IACK && host_write_i
        |=> pci_req_o && pci_cmd_o == CMD_SPECIAL)
        else $error("iack write did not give special cycle");
    AST_IO_CMD: assert property (
        host_req_i && win == HPT_WIN_IO
        |=> pci_req_o && pci_cmd_o == ($past(host_write_i) ? CMD_IO_WR : CMD_IO_RD))
        else $error("sparse i/o command wrong");
    AST_IO_ADDR: assert property (
        host_req_i && win == HPT_WIN_IO |=> pci_ad_o[23:3] == $past(host_address_i[28:8]))
        else $error("sparse i/o quadword address wrong");
    AST_EXT_SELECT: assert property (
        host_req_i && win == HPT_WIN_IO
        |=> pci_ad_o[31:24] == (($past(host_address_i[28:23]) == 6'h00) ?
            FIXED_EXT_VAL : $past(prog_ext_q[31:24])))
        else $error("extension register selection wrong");
    AST_BYTE_LANE: assert property (
        host_req_i && win == HPT_WIN_IO && host_address_i[4:3] == 2'h0
        |=> pci_cbe_n_o == ~(4'h1 << $past(host_address_i[6:5])) && pci_ad_o[1:0] ==
            $past(host_address_i[6:5]))
        else $error("byte lane enable wrong");
    AST_QUAD_LOW: assert property (
        host_req_i && win != HPT_WIN_NONE && host_address_i[6:3] == 4'hF
        && !(win == HPT_WIN_IACK && host_write_i)
        |=> pci_cbe_n_o == 4'h0 && (pci_ad_o[2:0] == 3'h0 || $past(win) == HPT_WIN_CFG))
        else $error("quadword enables or low address wrong");
    AST_ILLEGAL_DONE: assert property (
        host_req_i && win != HPT_WIN_NONE && !lane_legal && !host_write_i
        |=> pci_req_o ##1 !pci_req_o || $past(host_req_i))
        else $error("illegal combination not completed");
    AST_CFG_CMD_BUS: assert property (
        host_req_i && win == HPT_WIN_CFG
        |=> pci_cmd_o == ($past(host_write_i) ? CMD_CFG_WR : CMD_CFG_RD)
            && pci_ad_o[1:0] == $past(prog_ext_q[1:0]))
        else $error("config command or bus select wrong");
    AST_IDSEL_ONEHOT: assert property (
        host_req_i && win == HPT_WIN_CFG && prog_ext_q[1:0] == BUS_PRIMARY
        |=> $onehot0(pci_ad_o[31:11])
            && ((pci_ad_o[31:11] == '0) == ($past(dev) > IDSEL_MAX_DEV)))
        else $error("primary idsel decode wrong");
    AST_CFG_FIELDS: assert property (
        host_req_i && win == HPT_WIN_CFG |=> pci_ad_o[10:2] == $past(host_address_i[15:7]))
        else $error("function or register select wrong");
    AST_SECONDARY: assert property (
        host_req_i && win == HPT_WIN_CFG && prog_ext_q[1:0] == BUS_SECONDARY
        |=> pci_ad_o[31:24] == 8'h00 && pci_ad_o[23:11] == $past(host_address_i[28:16]))
        else $error("secondary config fields wrong");
    COV_IACK: cover property (host_req_i && win == HPT_WIN_IACK ##1 pci_req_o);
    COV_IO_PROG: cover property (host_req_i && win == HPT_WIN_IO && ext_hi != FIXED_EXT_VAL);
    COV_CFG_SEC: cover property (host_req_i && win == HPT_WIN_CFG && prog_ext_q[1:0] == 2'h1);
    COV_APB_WRITE: cover property (apb_write && paddr_i == REG_PROG_EXT);
endmodule : hpt_bridge

// ==== tb/hpt_pci_far_model.sv ====
// Purpose: far-side pci target and pci-to-pci bridge model
// Assumes: one address phase per pci_req_i pulse
// Notes: claim outputs are combinational on the address phase
`timescale 1ns/1ps
module hpt_pci_far_model
    import hpt_pkg::*;
#(
    parameter int MY_DEV = 5,
    parameter logic [7:0] SEC_BUS = 8'h03,
    parameter logic [7:0] SUB_BUS = 8'h07
)
(
    input wire logic pci_req_i,
    input wire logic [3:0] pci_cmd_i,
    input wire logic [31:0] pci_ad_i,
    output logic tgt_claim_o,
    output logic brg_claim_o,
    output logic brg_fwd_o
);
    logic is_cfg;
    logic is_sec;
    assign is_cfg = pci_req_i && (pci_cmd_i == CMD_CFG_RD || pci_cmd_i == CMD_CFG_WR);
    assign is_sec = is_cfg && (pci_ad_i[1:0] == BUS_SECONDARY);
    assign tgt_claim_o = is_cfg && pci_ad_i[11 + MY_DEV] && (pci_ad_i[1:0] == BUS_PRIMARY);
    assign brg_claim_o = is_sec && (pci_ad_i[23:16] == SEC_BUS);
    assign brg_fwd_o = is_sec && (pci_ad_i[23:16] > SEC_BUS) && (pci_ad_i[23:16] <= SUB_BUS);
endmodule : hpt_pci_far_model

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the host to pci translator
// Assumes: zero-wait apb slave, host answer one cycle after request
// Notes: expected values are worked out by exp_fn
`timescale 1ns/1ps
module tb;
    import hpt_pkg::*;
    typedef struct packed {
        logic miss;
        logic ill;
        logic [3:0] cmd;
        logic [3:0] cbe;
        logic [31:0] ad;
    } hpt_exp_s;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic host_req_i = 1'b0;
    logic host_write_i = 1'b0;
    logic [HOST_AW-1:0] host_address_i = '0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [APB_AW-1:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0;
    logic pci_req_o, pci_illegal_o, host_miss_o, pready_o, pslverr_o;
    logic tgt, brg, fwd, se, pend_v;
    logic [1:0] brg_exp;
    logic [3:0] pci_cmd_o, pci_cbe_n_o;
    logic [31:0] pci_ad_o, prdata_o, rd, r, r2;
    logic [31:0] prog = PROG_EXT_RST;
    logic [33:0] a;
    hpt_exp_s pend;
    int n_mismatch = 0;
    int compares = 0;
    int hits = 0;
    integer seed = 32'h312A20EC;

    always #12.5 sys_clk_i = ~sys_clk_i;

    hpt_bridge dut (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .host_req_i(host_req_i),
        .host_write_i(host_write_i), .host_address_i(host_address_i),
        .pci_req_o(pci_req_o), .pci_cmd_o(pci_cmd_o), .pci_ad_o(pci_ad_o),
        .pci_cbe_n_o(pci_cbe_n_o), .pci_illegal_o(pci_illegal_o), .host_miss_o(host_miss_o),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o)
    );
    hpt_pci_far_model far (
        .pci_req_i(pci_req_o), .pci_cmd_i(pci_cmd_o), .pci_ad_i(pci_ad_o),
        .tgt_claim_o(tgt), .brg_claim_o(brg), .brg_fwd_o(fwd)
    );

    function automatic hpt_exp_s exp_fn(input logic [33:0] ha, input logic w,
                                        input logic [31:0] px);
        hpt_exp_s e;
        logic [3:0] m;
        logic [2:0] lo;
        logic [20:0] sel;
        e = '0;
        m = (4'h2 << ha[4:3]) - 4'h1;
        e.ill = (ha[4:3] == 2'h1 && ha[6:5] == 2'h3) || (ha[4:3] == 2'h2 && ha[6])
            || (ha[4:3] == 2'h3 && ^ha[6:5]);
        e.cbe = e.ill ? 4'hF : (ha[4:3] == 2'h3) ? 4'h0 : ~(m << ha[6:5]);
        lo = (ha[6:3] == 4'hF) ? 3'h0 : {ha[7], ha[6:5]};
        sel = (ha[20:16] <= IDSEL_MAX_DEV) ? (21'h1 << ha[20:16]) : 21'h0;
        e.miss = ha[33:32] != QUAD_IO || ha[31:28] < WIN_IACK_CODE;
        if (ha[31:28] == WIN_IACK_CODE)
        begin
            e.cmd = w ? CMD_SPECIAL : CMD_IACK;
            e.cbe = w ? 4'h0 : e.cbe;
            e.ill = w ? 1'b0 : e.ill;
        end
        else if (ha[31:29] == WIN_IO_CODE)
        begin
            e.cmd = w ? CMD_IO_WR : CMD_IO_RD;
            e.ad = {(ha[28:23] == 6'h0) ? FIXED_EXT_VAL : px[31:24], ha[28:8], lo};
        end
        else
        begin
            e.cmd = w ? CMD_CFG_WR : CMD_CFG_RD;
            e.ad = (px[1:0] == BUS_PRIMARY) ? {sel, ha[15:7], 2'h0} : {8'h0, ha[28:7], px[1:0]};
        end
        return e;
    endfunction : exp_fn

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic host_op(input logic [33:0] ha, input logic w);
        hpt_exp_s e;
        e = exp_fn(ha, w, prog);
        hits += !e.miss;
        host_req_i <= 1'b1;
        host_write_i <= w;
        host_address_i <= ha;
        @(posedge sys_clk_i);
    endtask : host_op

    task automatic apb(input logic w, input logic [APB_AW-1:0] ad, input logic [31:0] wd);
        int n;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= ad;
        pwdata_i <= wd;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 50);
        if (pready_o !== 1'b1)
            n_mismatch++;
        rd = prdata_o;
        se = pslverr_o;
        if (w && ad == REG_PROG_EXT)
            prog = wd;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : apb

    task report_and_stop;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    assign brg_exp = {pend.ad[23:16] == 8'h03, pend.ad[23:16] inside {[8'h04:8'h07]}}
        & {2{pend.cmd[3] && pend.ad[1:0] == BUS_SECONDARY}};

    always @(posedge sys_clk_i)
    begin
        pend_v <= host_req_i;
        pend <= exp_fn(host_address_i, host_write_i, prog);
    end

    always @(negedge sys_clk_i)
    begin
        if (!reset_i)
        begin
            chk("req", pci_req_o, pend_v && !pend.miss);
            chk("miss", host_miss_o, pend_v && pend.miss);
            if (pend_v && !pend.miss)
            begin
                chk("cmd", pci_cmd_o, pend.cmd);
                chk("ad", pci_ad_o, pend.ad);
                chk("cbe", pci_cbe_n_o, pend.cbe);
                chk("ill", pci_illegal_o, pend.ill);
                chk("tgt", tgt, pend.cmd[3] && pend.ad[1:0] == 2'h0 && pend.ad[16]);
                chk("brg", {brg, fwd}, brg_exp);
            end
        end
    end

    initial
    begin
        #(25 * 5000);
        n_mismatch++;
        report_and_stop();
    end

    initial
    begin
        repeat (12) @(posedge sys_clk_i);
        chk("cbe_rst", pci_cbe_n_o, 4'hF);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        apb(1'b1, REG_FIXED_EXT, 32'hFFFF_FFFF);
        apb(1'b0, REG_FIXED_EXT, 32'h0);
        chk("fixed", rd, {24'h0, FIXED_EXT_VAL});
        apb(1'b0, REG_PROG_EXT, 32'h0);
        chk("prog_rst", rd, PROG_EXT_RST);
        apb(1'b0, 12'h00C, 32'h0);
        chk("slverr", se, 1'b1);
        apb(1'b1, REG_PROG_EXT, 32'hA500_0000);
        apb(1'b0, REG_PROG_EXT, 32'h0);
        chk("prog", rd, prog);
        // every lane code in the config window, and all but lane code 4'hF in the i/o window
        for (int i = 0; i < 32; i++)
        begin
            r = $random(seed);
            a = {2'h1, i[4] ? 4'hE : 4'hC, r[27:7], i[3:0], 3'h0};
            a[27:23] = i[1] ? 5'h0 : a[27:23];
            if (i != 15)
                host_op(a, r[0]);
        end
        // every primary device number
        for (int i = 0; i < 32; i++)
        begin
            r = $random(seed);
            host_op({2'h1, 4'hE, r[27:21], i[4:0], r[15:7], 4'h6, 3'h0}, r[0]);
        end
        for (int i = 0; i < 16; i++)
        begin
            r = $random(seed);
            host_op({2'h1, 4'hB, r[27:7], i[3:0], 3'h0}, 1'b0);
            host_op({2'h1, 4'hB, r[27:7], 4'h3, 3'h0}, 1'b1);
        end
        host_req_i <= 1'b0;
        @(posedge sys_clk_i);
        apb(1'b1, REG_PROG_EXT, 32'h5A00_0001);
        for (int i = 0; i < 10; i++)
        begin
            r = $random(seed);
            host_op({2'h1, 3'h7, i[7:0], r[20:3], 3'h0}, r[0]);
        end
        for (int k = 0; k < 400; k++)
        begin
            r = $random(seed);
            r2 = $random(seed);
            a = {r[8] ? QUAD_IO : r[10:9], r[31:28], r2[27:0]};
            if ((a[31:28] == WIN_IACK_CODE && r[0]) || (a[31:29] == WIN_IO_CODE && &a[6:3]))
                a[6:3] = 4'h3;
            host_op(a, r[0]);
        end
        host_op({2'h1, 4'hC, 21'h0, 4'h7, 3'h0}, 1'b0);
        host_op(34'h0, 1'b0);
        host_req_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("count", rd[15:0], hits[15:0]);
        chk("st_cmd", rd[ST_CMD_LSB +: 4], CMD_IO_RD);
        chk("st_ill", rd[ST_ILLEGAL_BIT], 1'b1);
        chk("st_miss", rd[ST_MISS_BIT], 1'b1);
        // mid-run reset restores the programmable register
        reset_i <= 1'b1;
        prog = PROG_EXT_RST;
        repeat (2) @(posedge sys_clk_i);
        chk("cbe_rst2", pci_cbe_n_o, 4'hF);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        apb(1'b0, REG_PROG_EXT, 32'h0);
        chk("prog_rst2", rd, PROG_EXT_RST);
        report_and_stop();
    end
endmodule : tb
